// ===== design/phy_bmc_cfg.svh
/*
 * Constants for the basic mode control register block: address, bit
 * positions, loop-off and default speed values and timing counts.
 * Assumes a 200 MHz core clock; included by the package and modules.
 */
`ifndef PHY_BMC_CFG_SVH
`define PHY_BMC_CFG_SVH

`define MGMT_ADDR_W 5
`define MGMT_DATA_W 16
`define BMC_ADDR 5'h00
`define BMC_RESET_BIT 15
`define BMC_LOOP_BIT 14
`define BMC_SPEED_BIT 13
`define BMC_AN_BIT 12
`define BMC_RSVD_BIT 11
`define BMC_LOW_W 11
`define RD_ZERO 16'h0000

`define CLK_PERIOD_PS 5000
`define DEAD_TIME_US 550
`define DEAD_CYCLES ((`DEAD_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define DEAD_CNT_W 17

`define HOLD_CYCLES 4'h8
`define HOLD_W 4
`define HOLD_ONE 4'h1

`define LOOP_CTL_OFF 2'h0
`define SPEED_DEFAULT 1'b1

`endif

// ===== design/phy_bmc_pkg.sv
/*
 * Types for the basic mode control register block.
 * Assumes phy_bmc_cfg.svh supplies the widths.
 */
`include "phy_bmc_cfg.svh"

package phy_bmc_pkg;

    typedef enum logic [1:0] {
        ST_CAPTURE,
        ST_LOAD,
        ST_HOLD,
        ST_IDLE
    } seq_state_t;

    typedef struct packed {
        seq_state_t seq;
        logic [`HOLD_W-1:0] hold_cnt;
        logic loopback;
        logic speed;
        logic an_en;
        logic an_armed;
        logic an_active;
        logic speed_100;
        logic regs_default;
        logic [1:0] ext_loop;
        logic [`MGMT_DATA_W-1:0] rdata;
        logic rvalid;
        logic dead_start;
    } ctl_t;

    typedef struct packed {
        logic pin_low;
        logic pin_high;
    } strap_t;

    typedef struct packed {
        logic active;
        logic [`DEAD_CNT_W-1:0] cnt;
    } dead_t;

endpackage

// ===== design/phy_bmc_strap.sv
/*
 * Strap latch: holds the two auto-negotiation strap levels.
 * Assumes the pins are steady whenever capture is high.
 */
`timescale 1ns/1ps
`default_nettype none

module phy_bmc_strap
    import phy_bmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic capture,
    input wire logic neg_strap_pin_low,
    input wire logic neg_strap_pin_high,
    output logic latched_low,
    output logic latched_high
);
    strap_t st_r;
    strap_t st_nxt;

    // levels are caught by the clock, never by the async reset
    always_comb begin
        st_nxt = st_r;
        if (capture) begin
            st_nxt.pin_low = neg_strap_pin_low;
            st_nxt.pin_high = neg_strap_pin_high;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign latched_low = st_r.pin_low;
    assign latched_high = st_r.pin_high;

endmodule // phy_bmc_strap

`default_nettype wire

// ===== design/phy_bmc_dead.sv
/*
 * Dead-time timer: flags a window after loopback comes on at 100 Mb/s.
 * Assumes start is a one-cycle pulse; a new start restarts the window.
 */
`timescale 1ns/1ps
`default_nettype none
`include "phy_bmc_cfg.svh"

module phy_bmc_dead
    import phy_bmc_pkg::*;
#(
    parameter logic [`DEAD_CNT_W-1:0] CYCLES = `DEAD_CNT_W'(`DEAD_CYCLES)
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic start,
    output logic active
);
    dead_t st_r;
    dead_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (start) begin
            st_nxt.active = 1'b1;
            st_nxt.cnt = CYCLES;
        end else if (st_r.active) begin
            st_nxt.cnt = st_r.cnt - `DEAD_CNT_W'(1);
            st_nxt.active = (st_r.cnt > `DEAD_CNT_W'(1));
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign active = st_r.active;

endmodule // phy_bmc_dead

`default_nettype wire

// ===== design/phy_bmc_ctl.sv
/*
 * Basic mode control register, bits 15 to 11, on the register port of
 * the serial management engine, with software reset sequencing.
 * Assumes the management engine presents one-cycle read and write
 * strobes with a register address; bits 10 to 0 live elsewhere.
 */
// How it works
// - writing one to bit 15 returns all control/status registers to defaults
// - software reset re-latches strap pins like a hardware reset
// - reset bit self-clears; reads one until the sequence finishes
// - bit 14 loops MII transmit data into receive, both speeds
// - loopback on at 100 Mb/s twisted pair starts a 550 us dead window
// - bit 14 overrides the two loop control bits of register 18h
// - with negotiation off, bit 13 picks 100 or 10 Mb/s
// - latched strap levels set speed and the enable bit at each reset
// - bit 12 enables negotiation, then bits 13 and 8 are ignored
// - strapped-off negotiation needs enable written zero then one
// - bit 12 reads back the control value, never negotiation status
// - register sits at management address 0 of 32 word registers
`timescale 1ns/1ps
`default_nettype none
`include "phy_bmc_cfg.svh"

module phy_bmc_ctl
    import phy_bmc_pkg::*;
#(
    parameter logic [`DEAD_CNT_W-1:0] DEAD_CYCLES = `DEAD_CNT_W'(`DEAD_CYCLES)
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [`MGMT_ADDR_W-1:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [`MGMT_DATA_W-1:0] mgmt_wdata,
    output logic [`MGMT_DATA_W-1:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire logic [`BMC_LOW_W-1:0] low_bits_in,
    input wire logic neg_strap_pin_low,
    input wire logic neg_strap_pin_high,
    input wire logic an_speed_100,
    input wire logic tp_mode_100,
    input wire logic [1:0] lbr_loop_ctl,
    output logic regs_default,
    output logic mii_loopback,
    output logic [1:0] ext_loop_ctl,
    output logic speed_100,
    output logic an_enable,
    output logic dead_time
);
    ctl_t st_r;
    ctl_t st_nxt;
    logic strap_low;
    logic strap_high;
    logic wr_hit;
    logic rd_hit;

    function automatic logic is_bmc(input logic [`MGMT_ADDR_W-1:0] a);
        return a == `BMC_ADDR;
    endfunction

    assign wr_hit = mgmt_wr && is_bmc(mgmt_addr);
    assign rd_hit = mgmt_rd && is_bmc(mgmt_addr);

    phy_bmc_strap u_strap (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .capture(st_r.seq == ST_CAPTURE),
        .neg_strap_pin_low(neg_strap_pin_low),
        .neg_strap_pin_high(neg_strap_pin_high),
        .latched_low(strap_low),
        .latched_high(strap_high)
    );

    phy_bmc_dead #(
        .CYCLES(DEAD_CYCLES)
    ) u_dead (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(st_r.dead_start),
        .active(dead_time)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.dead_start = 1'b0;
        unique case (st_r.seq)
            ST_CAPTURE: begin
                st_nxt.regs_default = 1'b1;
                st_nxt.seq = ST_LOAD;
            end
            ST_LOAD: begin
                // strap high selects negotiation, otherwise strap low
                // forces the speed; a strapped-off start leaves the
                // enable disarmed until it is written zero
                st_nxt.loopback = 1'b0;
                st_nxt.an_en = strap_high;
                st_nxt.an_armed = strap_high;
                st_nxt.speed = strap_high ? `SPEED_DEFAULT : strap_low;
                st_nxt.hold_cnt = `HOLD_CYCLES;
                st_nxt.seq = ST_HOLD;
            end
            ST_HOLD: begin
                st_nxt.hold_cnt = st_r.hold_cnt - `HOLD_ONE;
                if (st_r.hold_cnt == `HOLD_ONE) begin
                    st_nxt.regs_default = 1'b0;
                    st_nxt.seq = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // writes during the reset sequence are dropped on purpose
                if (wr_hit && mgmt_wdata[`BMC_RESET_BIT]) begin
                    st_nxt.seq = ST_CAPTURE;
                end else if (wr_hit) begin
                    // bit 11 is not stored, it always reads zero
                    st_nxt.loopback = mgmt_wdata[`BMC_LOOP_BIT];
                    st_nxt.speed = mgmt_wdata[`BMC_SPEED_BIT];
                    st_nxt.an_en = mgmt_wdata[`BMC_AN_BIT];
                    if (!mgmt_wdata[`BMC_AN_BIT]) begin
                        st_nxt.an_armed = 1'b1;
                    end
                end
            end
        endcase
        st_nxt.an_active = st_nxt.an_en && st_nxt.an_armed;
        st_nxt.speed_100 = st_nxt.an_active ? an_speed_100
                                            : st_nxt.speed;
        st_nxt.ext_loop = st_nxt.loopback ? `LOOP_CTL_OFF
                                          : lbr_loop_ctl;
        st_nxt.dead_start = st_nxt.loopback && !st_r.loopback
                            && st_nxt.speed_100 && tp_mode_100;
        if (rd_hit) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = {st_r.seq != ST_IDLE,
                            st_r.loopback,
                            st_r.speed,
                            st_r.an_en,
                            1'b0,
                            low_bits_in};
        end else begin
            st_nxt.rdata = `RD_ZERO;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{seq: ST_CAPTURE, regs_default: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mgmt_rdata = st_r.rdata;
    assign mgmt_rvalid = st_r.rvalid;
    assign regs_default = st_r.regs_default;
    assign mii_loopback = st_r.loopback;
    assign ext_loop_ctl = st_r.ext_loop;
    assign speed_100 = st_r.speed_100;
    assign an_enable = st_r.an_active;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    a_swrst_start_busy: assert property (
        st_r.seq == ST_IDLE && wr_hit && mgmt_wdata[`BMC_RESET_BIT]
        |=> st_r.seq == ST_CAPTURE ##1 regs_default)
        else $error("software reset did not start");

    a_strap_recapture: assert property (
        st_r.seq == ST_CAPTURE
        |=> strap_low == $past(neg_strap_pin_low)
            && strap_high == $past(neg_strap_pin_high))
        else $error("strap levels not re-latched");

    a_reset_bit_clears: assert property (
        st_r.seq == ST_LOAD |-> ##9 st_r.seq == ST_IDLE && !regs_default)
        else $error("reset sequence length wrong");

    a_busy_read_one: assert property (
        rd_hit && st_r.seq != ST_IDLE |=> mgmt_rdata[`BMC_RESET_BIT])
        else $error("reset bit read zero while busy");

    a_loop_write: assert property (
        st_r.seq == ST_IDLE && wr_hit && !mgmt_wdata[`BMC_RESET_BIT]
        |=> mii_loopback == $past(mgmt_wdata[`BMC_LOOP_BIT]))
        else $error("loopback bit not applied");

    a_dead_window: assert property (
        st_r.dead_start |=> dead_time)
        else $error("dead window not opened");

    a_loop_override: assert property (
        mii_loopback |-> ext_loop_ctl == `LOOP_CTL_OFF)
        else $error("loop control not overridden");

    a_speed_select: assert property (
        ##1 speed_100 == (an_enable ? $past(an_speed_100) : st_r.speed))
        else $error("effective speed wrong");

    a_strap_forced: assert property (
        st_r.seq == ST_LOAD && !strap_high
        |=> !an_enable && st_r.speed == $past(strap_low))
        else $error("strap defaults not applied");

    a_an_rearm: assert property (
        st_r.seq == ST_IDLE && !st_r.an_armed && wr_hit
        && !mgmt_wdata[`BMC_RESET_BIT]
        |=> an_enable == 1'b0)
        else $error("negotiation enabled without re-arm");

    a_an_readback: assert property (
        rd_hit |=> mgmt_rdata[`BMC_AN_BIT] == $past(st_r.an_en)
                   && !mgmt_rdata[`BMC_RSVD_BIT])
        else $error("enable bit readback wrong");

    a_read_answer: assert property (
        rd_hit |=> mgmt_rvalid)
        else $error("read of address 0 not answered");

    a_quiet_no_read: assert property (
        !rd_hit |=> !mgmt_rvalid && mgmt_rdata == `RD_ZERO)
        else $error("read port active without a read");

    a_other_addr: assert property (
        mgmt_rd && !is_bmc(mgmt_addr) |=> !mgmt_rvalid)
        else $error("other address answered");

    a_idle_read_zero: assert property (
        rd_hit && st_r.seq == ST_IDLE |=> !mgmt_rdata[`BMC_RESET_BIT])
        else $error("reset bit read one after the sequence");

    a_busy_drops_write: assert property (
        st_r.seq == ST_HOLD && wr_hit
        |=> $stable(mii_loopback) && $stable(st_r.speed)
            && $stable(st_r.an_en))
        else $error("write taken during reset sequence");

    a_defaults_held: assert property (
        (st_r.seq == ST_LOAD || st_r.seq == ST_HOLD) |-> regs_default)
        else $error("defaults released too early");

    a_idle_released: assert property (
        st_r.seq == ST_IDLE |-> !regs_default)
        else $error("defaults still forced when idle");

    a_load_clears_loop: assert property (
        st_r.seq == ST_LOAD |=> !mii_loopback)
        else $error("loopback survived reset");

    a_strap_an_default: assert property (
        st_r.seq == ST_LOAD && strap_high |=> an_enable && st_r.speed)
        else $error("strapped negotiation not applied");

    a_speed_forced: assert property (
        !an_enable |-> speed_100 == st_r.speed)
        else $error("forced speed not from bit 13");

    a_loop_passthru: assert property (
        !st_nxt.loopback |=> ext_loop_ctl == $past(lbr_loop_ctl))
        else $error("loop control not passed through");

    a_dead_cause: assert property (
        st_r.dead_start |-> mii_loopback && speed_100
                            && $past(tp_mode_100))
        else $error("dead window without its cause");

    a_dead_on_rise: assert property (
        mii_loopback && !$past(mii_loopback) && speed_100
        && $past(tp_mode_100) |-> st_r.dead_start)
        else $error("dead window not started");

    a_read_fields: assert property (
        rd_hit |=> mgmt_rdata[`BMC_LOOP_BIT] == $past(st_r.loopback)
                   && mgmt_rdata[`BMC_SPEED_BIT] == $past(st_r.speed))
        else $error("loopback or speed readback wrong");

    a_low_bits_pass: assert property (
        rd_hit |=> mgmt_rdata[`BMC_LOW_W-1:0] == $past(low_bits_in))
        else $error("low bits not returned");

    a_an_clear_arms: assert property (
        st_r.seq == ST_IDLE && wr_hit && !mgmt_wdata[`BMC_RESET_BIT]
        && !mgmt_wdata[`BMC_AN_BIT] |=> !an_enable && st_r.an_armed)
        else $error("clearing enable did not arm");

    a_an_armed_write: assert property (
        st_r.seq == ST_IDLE && st_r.an_armed && wr_hit
        && !mgmt_wdata[`BMC_RESET_BIT]
        |=> an_enable == $past(mgmt_wdata[`BMC_AN_BIT]))
        else $error("armed enable write not applied");

    a_strap_steady: assert property (
        st_r.seq != ST_CAPTURE |=> $stable(strap_low) && $stable(strap_high))
        else $error("strap levels moved outside capture");

    a_hold_count: assert property (
        st_r.seq == ST_HOLD |-> |st_r.hold_cnt)
        else $error("hold counter ran out");

    a_capture_to_load: assert property (
        st_r.seq == ST_CAPTURE |=> st_r.seq == ST_LOAD)
        else $error("capture not followed by load");

endmodule // phy_bmc_ctl

`default_nettype wire

// ===== verification/mgmt_station.sv
/*
 * Station management model: issues register port reads and writes.
 * Assumes one-cycle strobes sampled on the rising edge of core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module mgmt_station (
    input wire logic core_clk,
    output logic [4:0] mgmt_addr,
    output logic mgmt_wr,
    output logic mgmt_rd,
    output logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid
);
    initial begin
        mgmt_addr = 5'h00;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_wdata = 16'h0000;
    end

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1;
        mgmt_addr = a;
        mgmt_wdata = d & 16'hF7FF; // reserved bit always sent as zero
        mgmt_wr = 1'b1;
        @(posedge core_clk);
        #1;
        mgmt_wr = 1'b0;
        // released data must not keep its value
        mgmt_wdata = ~mgmt_wdata;
    endtask

    task automatic rd_reg(input logic [4:0] a, output logic [15:0] d,
                          output logic v);
        int i;
        @(posedge core_clk);
        #1;
        mgmt_addr = a;
        mgmt_rd = 1'b1;
        @(posedge core_clk);
        #1;
        mgmt_rd = 1'b0;
        v = 1'b0;
        d = 16'h0000;
        for (i = 0; i < 3; i++) begin
            if (mgmt_rvalid === 1'b1 && !v) begin
                v = 1'b1;
                d = mgmt_rdata;
            end
            @(posedge core_clk);
            #1;
        end
    endtask
endmodule // mgmt_station

`default_nettype wire

// ===== verification/testbench.sv
/*
 * Testbench for the basic mode control register, bits 15 to 11.
 * Assumes the station model drives the register port; short dead time.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import phy_bmc_pkg::*;
    logic core_clk, reset_n, mgmt_wr, mgmt_rd, mgmt_rvalid, v;
    logic [4:0] mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata, rd;
    logic s_low, s_high, an_spd, tp, regs_def, loop, spd, an_en, dead;
    logic [1:0] lbr, ext;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    phy_bmc_ctl #(.DEAD_CYCLES(17'h14)) u_phy_bmc_ctl (
        .core_clk(core_clk), .reset_n(reset_n), .mgmt_addr(mgmt_addr),
        .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
        .low_bits_in(11'h5A5), .neg_strap_pin_low(s_low),
        .neg_strap_pin_high(s_high), .an_speed_100(an_spd),
        .tp_mode_100(tp), .lbr_loop_ctl(lbr), .regs_default(regs_def),
        .mii_loopback(loop), .ext_loop_ctl(ext), .speed_100(spd),
        .an_enable(an_en), .dead_time(dead));

    mgmt_station u_mgmt_station (
        .core_clk(core_clk), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
        .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // generous ceiling: the full run needs well under 500 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp);
        check({15'h0, seen}, {15'h0, exp});
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // read address 0, expect an answer and the given word
    task automatic rchk(input logic [15:0] exp);
        u_mgmt_station.rd_reg(5'h00, rd, v);
        chk1(v, 1'b1);
        check(rd, exp);
    endtask

    task automatic wr0(input logic [15:0] d);
        u_mgmt_station.wr_reg(5'h00, d);
        step(1);
    endtask

    initial begin
        reset_n = 1'b0;
        s_low = 1'b0;
        s_high = 1'b1;
        an_spd = 1'b1;
        tp = 1'b1;
        lbr = 2'h2;
        step(12);
        reset_n = 1'b1;
        step(12);
        rchk(16'h35A5);
        chk1(an_en, 1'b1);
        chk1(spd, 1'b1);
        an_spd = 1'b0;
        step(2);
        chk1(spd, 1'b0); // bit 13 still one but ignored
        u_mgmt_station.rd_reg(5'h05, rd, v);
        chk1(v, 1'b0);
        $display("test defaults done");
        wr0(16'h0000);
        chk1(spd, 1'b0);
        chk1(an_en, 1'b0);
        rchk(16'h05A5);
        wr0(16'h2000);
        chk1(spd, 1'b1);
        check({14'h0, ext}, 16'h0002);
        $display("test forced speed done");
        wr0(16'h6800);
        chk1(loop, 1'b1);
        check({14'h0, ext}, 16'h0000);
        step(1);
        chk1(dead, 1'b1);
        rchk(16'h65A5);
        step(30);
        chk1(dead, 1'b0);
        wr0(16'h0000);
        wr0(16'h4000);
        step(1);
        chk1(dead, 1'b0); // 10 Mb/s loopback opens no window
        wr0(16'h0000);
        tp = 1'b0;
        wr0(16'h6000);
        step(1);
        chk1(dead, 1'b0); // not twisted pair, no window
        tp = 1'b1;
        wr0(16'h2000);
        step(1);
        check({14'h0, ext}, 16'h0002);
        $display("test loopback done");
        s_high = 1'b0;
        s_low = 1'b1;
        wr0(16'h8000); // long after power-up; wait shortened
        chk1(regs_def, 1'b1);
        wr0(16'h4000); // dropped while the sequence runs
        u_mgmt_station.rd_reg(5'h00, rd, v);
        chk1(rd[15], 1'b1);
        step(12);
        rchk(16'h25A5);
        chk1(regs_def, 1'b0);
        chk1(spd, 1'b1);
        chk1(loop, 1'b0);
        $display("test soft reset done");
        wr0(16'h1000);
        chk1(an_en, 1'b0);
        wr0(16'h0000);
        wr0(16'h3000);
        chk1(an_en, 1'b1);
        chk1(spd, 1'b0); // bit 13 ignored once enabled
        $display("test rearm done");
        finish_test();
    end
endmodule // testbench

`default_nettype wire
